/* File: spbcg_consts.svh */
`ifndef SPBCG_CONSTS_SVH
`define SPBCG_CONSTS_SVH

`define SPBCG_AW 5
`define SPBCG_OFF_DATA 5'h00
`define SPBCG_OFF_STAT 5'h04
`define SPBCG_OFF_CTRL 5'h08
`define SPBCG_OFF_DIV 5'h0C

`define SPBCG_ST_RXC 0
`define SPBCG_ST_TXC 1
`define SPBCG_ST_DRE 2
`define SPBCG_ST_FE 3
`define SPBCG_ST_DOR 4
`define SPBCG_ST_PE 5
`define SPBCG_ST_DBL 6

`define SPBCG_CT_RXEN 0
`define SPBCG_CT_TXEN 1
`define SPBCG_CT_SYNC 2
`define SPBCG_CT_POL 3
`define SPBCG_CT_DIR 4
`define SPBCG_CT_STOP2 5
`define SPBCG_CT_PAREN 6
`define SPBCG_CT_PARODD 7
`define SPBCG_CT_SIZE 8
`define SPBCG_CT_PWR 11
`define SPBCG_CT_IE 12

`define SPBCG_DIV_RST 12'h000
`define SPBCG_FACT_NORM 5'h10
`define SPBCG_FACT_DBL 5'h08
`define SPBCG_FRAME_W 13
`define SPBCG_RESP_OK 2'h0
`define SPBCG_RESP_ERR 2'h2

`endif

/* File: spbcg_core.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "spbcg_consts.svh"
module spbcg_core
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire spbcg_pkg::spbcg_axi_req_s axi_req,
	output spbcg_pkg::spbcg_axi_rsp_s axi_rsp,
	input wire spbcg_pkg::spbcg_pin_in_s pin_in,
	output spbcg_pkg::spbcg_pin_out_s pin_out,
	output spbcg_pkg::spbcg_irq_s irq
);
	import spbcg_pkg::*;

	spbcg_state_s q;
	spbcg_state_s d;
	spbcg_mode_e mode;
	logic [4:0] ovs;
	logic [3:0] last;
	logic [3:0] midp;
	logic [3:0] nb;
	logic [3:0] tlen;
	logic [`SPBCG_FRAME_W-1:0] frm;
	logic wr_go;
	logic rd_go;
	logic lowwr;
	logic pop;
	logic tick;
	logic ckv;
	logic ckp;
	logic rise;
	logic fall;
	logic chg;
	logic smp;
	logic tx_str;
	logic bit_v;
	logic bit_val;
	logic fdone;

	////////////////////////////////////////////////////////////////////////////////
	function automatic spbcg_mode_e mode_of(input logic sy, input logic dr, input logic db);
		if (sy)
			mode_of = dr ? MD_MASTER : MD_SLAVE;
		else
			mode_of = db ? MD_DOUBLE : MD_NORMAL;
	endfunction : mode_of

	function automatic logic [3:0] data_bits(input logic [2:0] sz);
		data_bits = (sz > 3'h4) ? 4'h9 : ({1'b0, sz} + 4'h5);
	endfunction : data_bits

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : maj3

	// Unused upper positions stay high so they supply the stop bits.
	function automatic logic [`SPBCG_FRAME_W-1:0] tx_frame(input logic [8:0] dat, input logic [3:0] n,
		input logic pen, input logic podd);
		logic [`SPBCG_FRAME_W-1:0] f;
		logic p;
		f = '1;
		p = podd;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			if (4'(i) < n)
			begin
				f[i + 1] = dat[i];
				p = p ^ dat[i];
			end
		end
		if (pen)
			f[n + 4'h1] = p;
		tx_frame = f;
	endfunction : tx_frame

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		mode = mode_of(q.sync, q.dir, q.dbl);
		ovs = (mode == MD_DOUBLE) ? `SPBCG_FACT_DBL : `SPBCG_FACT_NORM;
		last = 4'(ovs - 5'h01);
		midp = 4'((ovs >> 1) + 5'h01);
		nb = data_bits(q.size);
		frm = tx_frame(q.txbuf, nb, q.par_en, q.par_odd);
		tlen = 4'h2 + nb + {3'h0, q.par_en} + {3'h0, q.stop2};
		wr_go = axi_req.awvalid & axi_req.wvalid & ~q.bvalid;
		rd_go = axi_req.arvalid & ~q.rvalid;
		lowwr = 1'b0;
		pop = 1'b0;
		tick = 1'b0;
		bit_v = 1'b0;
		bit_val = 1'b1;
		fdone = 1'b0;

		// Register writes; address and data are taken together in one beat.
		if (q.bvalid & axi_req.bready)
			d.bvalid = 1'b0;
		if (wr_go)
		begin
			d.bvalid = 1'b1;
			d.bresp = `SPBCG_RESP_OK;
			case (axi_req.awaddr)
				`SPBCG_OFF_DATA:
				begin
					// A write while the buffer is full is dropped.
					if (axi_req.wstrb[0] & ~q.txfull)
					begin
						d.txbuf = axi_req.wdata[8:0];
						d.txfull = 1'b1;
					end
				end
				`SPBCG_OFF_STAT:
				begin
					if (axi_req.wstrb[0])
					begin
						d.dbl = axi_req.wdata[`SPBCG_ST_DBL];
						if (axi_req.wdata[`SPBCG_ST_TXC])
							d.txc = 1'b0;
					end
				end
				`SPBCG_OFF_CTRL:
				begin
					if (axi_req.wstrb[0])
					begin
						d.rx_en = axi_req.wdata[`SPBCG_CT_RXEN];
						d.tx_en = axi_req.wdata[`SPBCG_CT_TXEN];
						d.sync = axi_req.wdata[`SPBCG_CT_SYNC];
						d.pol = axi_req.wdata[`SPBCG_CT_POL];
						d.dir = axi_req.wdata[`SPBCG_CT_DIR];
						d.stop2 = axi_req.wdata[`SPBCG_CT_STOP2];
						d.par_en = axi_req.wdata[`SPBCG_CT_PAREN];
						d.par_odd = axi_req.wdata[`SPBCG_CT_PARODD];
					end
					if (axi_req.wstrb[1])
					begin
						d.size = axi_req.wdata[`SPBCG_CT_SIZE +: 3];
						d.pwr_off = axi_req.wdata[`SPBCG_CT_PWR];
						d.ie = axi_req.wdata[`SPBCG_CT_IE +: 3];
					end
				end
				`SPBCG_OFF_DIV:
				begin
					if (axi_req.wstrb[1])
						d.div[11:8] = axi_req.wdata[11:8];
					if (axi_req.wstrb[0])
					begin
						d.div[7:0] = axi_req.wdata[7:0];
						lowwr = 1'b1;
					end
				end
				default:
					d.bresp = `SPBCG_RESP_ERR;
			endcase
		end

		// Register reads; a data read pops the receive buffer and clears overrun.
		if (q.rvalid & axi_req.rready)
			d.rvalid = 1'b0;
		if (rd_go)
		begin
			d.rvalid = 1'b1;
			d.rresp = `SPBCG_RESP_OK;
			d.rdata = '0;
			case (axi_req.araddr)
				`SPBCG_OFF_DATA:
				begin
					d.rdata[8:0] = q.fq[0][8:0];
					pop = (q.fcnt != 2'h0);
					d.dor = 1'b0;
				end
				`SPBCG_OFF_STAT:
				begin
					d.rdata[`SPBCG_ST_RXC] = (q.fcnt != 2'h0);
					d.rdata[`SPBCG_ST_TXC] = q.txc;
					d.rdata[`SPBCG_ST_DRE] = ~q.txfull;
					d.rdata[`SPBCG_ST_FE] = q.fq[0][10];
					d.rdata[`SPBCG_ST_DOR] = q.dor;
					d.rdata[`SPBCG_ST_PE] = q.fq[0][9];
					d.rdata[`SPBCG_ST_DBL] = q.dbl;
				end
				`SPBCG_OFF_CTRL:
				begin
					d.rdata[`SPBCG_CT_RXEN] = q.rx_en;
					d.rdata[`SPBCG_CT_TXEN] = q.tx_en;
					d.rdata[`SPBCG_CT_SYNC] = q.sync;
					d.rdata[`SPBCG_CT_POL] = q.pol;
					d.rdata[`SPBCG_CT_DIR] = q.dir;
					d.rdata[`SPBCG_CT_STOP2] = q.stop2;
					d.rdata[`SPBCG_CT_PAREN] = q.par_en;
					d.rdata[`SPBCG_CT_PARODD] = q.par_odd;
					d.rdata[`SPBCG_CT_SIZE +: 3] = q.size;
					d.rdata[`SPBCG_CT_PWR] = q.pwr_off;
					d.rdata[`SPBCG_CT_IE +: 3] = q.ie;
				end
				`SPBCG_OFF_DIV:
					d.rdata[11:0] = q.div;
				default:
					d.rresp = `SPBCG_RESP_ERR;
			endcase
		end
		if (pop)
		begin
			d.fq[0] = q.fq[1];
			d.fcnt = q.fcnt - 2'h1;
		end

		////////////////////////////////////////////////////////////////////////////
		// Baud generator. A low-byte write restarts the count at once, so a new
		// rate takes hold without waiting out the old period.
		if (lowwr)
			d.bcnt = d.div;
		else if (q.pwr_off)
			d.bcnt = q.bcnt;
		else if (q.bcnt == 12'h000)
		begin
			tick = 1'b1;
			d.bcnt = q.div;
		end
		else
			d.bcnt = q.bcnt - 12'h001;

		// Synchronisers; the edge detector looks only at the second and third stages.
		d.xk_m1 = pin_in.xck;
		d.xk_m2 = q.xk_m1;
		d.xk_m3 = q.xk_m2;
		d.rx_m1 = pin_in.rxd;
		d.rx_m2 = q.rx_m1;

		// The master clock toggles per tick, which yields the factor of two.
		d.ck_prev = q.ck;
		if (mode != MD_MASTER)
			d.ck = q.pol;
		else if (tick)
			d.ck = ~q.ck;
		ckv = (mode == MD_SLAVE) ? q.xk_m2 : q.ck;
		ckp = (mode == MD_SLAVE) ? q.xk_m3 : q.ck_prev;
		rise = ckv & ~ckp;
		fall = ~ckv & ckp;
		chg = q.sync & (q.pol ? fall : rise);
		smp = q.sync & (q.pol ? rise : fall);

		if (~q.sync & tick)
			d.txdiv = (q.txdiv == last) ? 4'h0 : q.txdiv + 4'h1;
		tx_str = q.sync ? chg : (tick & (q.txdiv == last));

		////////////////////////////////////////////////////////////////////////////
		// Transmitter.
		if (~q.tx_en)
		begin
			d.txcnt = 4'h0;
			d.txact = 1'b0;
			d.txd = 1'b1;
		end
		else if (tx_str)
		begin
			if (q.txcnt != 4'h0)
			begin
				d.txd = q.txsh[0];
				d.txsh = {1'b1, q.txsh[`SPBCG_FRAME_W-1:1]};
				d.txcnt = q.txcnt - 4'h1;
			end
			else if (q.txfull)
			begin
				d.txd = frm[0];
				d.txsh = {1'b1, frm[`SPBCG_FRAME_W-1:1]};
				d.txcnt = tlen - 4'h1;
				d.txfull = 1'b0;
				d.txact = 1'b1;
			end
			else
			begin
				d.txd = 1'b1;
				d.txact = 1'b0;
				if (q.txact)
					d.txc = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Receiver; it never touches transmit state.
		if (~q.rx_en)
			d.rst = RX_IDLE;
		else if (q.rst == RX_IDLE)
		begin
			if ((q.sync ? smp : tick) & ~q.rx_m2)
			begin
				d.rst = RX_BUSY;
				d.rcnt = 4'h1;
				d.ridx = q.sync ? 4'h1 : 4'h0;
				d.rpar = q.par_odd;
				d.rpe = 1'b0;
				d.rdat = '0;
			end
		end
		else
		begin
			if (q.sync)
			begin
				bit_v = smp;
				bit_val = q.rx_m2;
			end
			else if (tick)
			begin
				d.rcnt = (q.rcnt == last) ? 4'h0 : q.rcnt + 4'h1;
				d.rsmp = {q.rsmp[1:0], q.rx_m2};
				bit_v = (q.rcnt == midp);
				bit_val = maj3({q.rsmp[1:0], q.rx_m2});
			end
			if (bit_v)
			begin
				if (q.ridx == 4'h0)
				begin
					if (bit_val)
						d.rst = RX_IDLE;
					else
						d.ridx = 4'h1;
				end
				else if (q.ridx <= nb)
				begin
					d.rdat[q.ridx - 4'h1] = bit_val;
					d.rpar = q.rpar ^ bit_val;
					d.ridx = q.ridx + 4'h1;
				end
				else if ((q.ridx == nb + 4'h1) & q.par_en)
				begin
					d.rpe = q.rpar ^ bit_val;
					d.ridx = q.ridx + 4'h1;
				end
				else
				begin
					// Only the first stop bit is checked.
					fdone = 1'b1;
					d.rst = RX_IDLE;
				end
			end
		end
		if (fdone)
		begin
			if (d.fcnt == 2'h2)
				d.dor = 1'b1;
			else
			begin
				d.fq[d.fcnt[0]] = {~bit_val, q.rpe, q.rdat};
				d.fcnt = d.fcnt + 2'h1;
			end
		end

		if (~aresetn)
		begin
			d = '0;
			d.div = `SPBCG_DIV_RST;
			d.txd = 1'b1;
			d.rst = RX_IDLE;
		end
	end

	always_ff @(posedge aclk)
		q <= d;

	////////////////////////////////////////////////////////////////////////////////
	assign axi_rsp.awready = wr_go;
	assign axi_rsp.wready = wr_go;
	assign axi_rsp.bvalid = q.bvalid;
	assign axi_rsp.bresp = q.bresp;
	assign axi_rsp.arready = rd_go;
	assign axi_rsp.rvalid = q.rvalid;
	assign axi_rsp.rresp = q.rresp;
	assign axi_rsp.rdata = q.rdata;
	assign pin_out.txd = q.txd;
	assign pin_out.xck_out = q.ck;
	assign pin_out.xck_oe = q.sync & q.dir;
	assign irq.rx_done = (q.fcnt != 2'h0) & q.ie[0];
	assign irq.tx_done = q.txc & q.ie[1];
	assign irq.tx_empty = ~q.txfull & q.ie[2];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_gap;
		!tick ##1 (tick || $past(wr_go));
	endsequence

	property p_div_one;
		(tick && q.div == 12'h001 && !wr_go) |=> s_gap;
	endproperty
	a_div_one: assert property (p_div_one) else $error("tick period wrong for divisor one");

	property p_reload;
		(q.bcnt == 12'h000 && !q.pwr_off && !lowwr) |=> (q.bcnt == $past(q.div));
	endproperty
	a_reload: assert property (p_reload) else $error("counter did not reload at zero");

	property p_lowwr;
		lowwr |=> (q.bcnt == q.div);
	endproperty
	a_lowwr: assert property (p_lowwr) else $error("low byte write did not reload");

	property p_async_pin;
		!q.sync |-> !pin_out.xck_oe;
	endproperty
	a_async_pin: assert property (p_async_pin) else $error("clock pin driven in async mode");

	property p_dir_pin;
		q.sync |-> (pin_out.xck_oe == q.dir);
	endproperty
	a_dir_pin: assert property (p_dir_pin) else $error("clock pin direction mismatch");

	property p_master_half;
		(mode == MD_MASTER && !tick) |=> $stable(q.ck);
	endproperty
	a_master_half: assert property (p_master_half) else $error("master clock moved without tick");

	property p_sync_mode;
		q.sync |-> (mode == MD_MASTER || mode == MD_SLAVE);
	endproperty
	a_sync_mode: assert property (p_sync_mode) else $error("double speed leaked into sync");

	property p_slave_delay;
		(mode == MD_SLAVE && $rose(pin_in.xck)) |-> ##2 (q.xk_m2 && !q.xk_m3);
	endproperty
	a_slave_delay: assert property (p_slave_delay) else $error("slave clock edge not two cycles late");

	property p_b2b;
		(q.tx_en && tx_str && q.txcnt == 4'h0 && q.txfull) |=> (!q.txd && q.txact && q.txcnt != 4'h0);
	endproperty
	a_b2b: assert property (p_b2b) else $error("buffered frame did not start at once");

	property p_overrun;
		(fdone && q.fcnt == 2'h2 && !pop) |=> q.dor;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_false_start;
		(q.rx_en && q.rst == RX_BUSY && bit_v && q.ridx == 4'h0 && bit_val) |=> (q.rst == RX_IDLE);
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start not rejected");

	property p_reset;
		disable iff (1'b0) !aresetn |=> (q.div == 12'h000 && q.bcnt == 12'h000 && !q.sync && !q.dbl);
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : spbcg_core

/* File: spbcg_core_tb.sv */
`timescale 1ns/1ns
`include "spbcg_consts.svh"
module spbcg_core_tb;
	import spbcg_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	spbcg_axi_req_s axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
	spbcg_axi_rsp_s axi_rsp;
	spbcg_pin_in_s pin_in;
	spbcg_pin_out_s pin_out;
	spbcg_irq_s irq;
	logic peer_rxd;
	logic peer_xck;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] rv;
	logic [1:0] rr;
	assign pin_in = {peer_rxd, peer_xck};
	always #5 aclk = ~aclk;
	spbcg_core u_spbcg_core (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.pin_in(pin_in), .pin_out(pin_out), .irq(irq));
	spbcg_peer u_spbcg_peer (.aclk(aclk), .txd(pin_out.txd), .rxd(peer_rxd), .xck(peer_xck));
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// Ready is combinational but stable between edges, so it is looked at on the falling edge
	// and the transfer completes at the following rising edge.
	task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= s;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		do @(negedge aclk); while ((axi_rsp.awready & axi_rsp.wready) !== 1'b1);
		@(posedge aclk);
		axi_req.awvalid <= 1'b0;
		axi_req.wvalid <= 1'b0;
		do @(negedge aclk); while (axi_rsp.bvalid !== 1'b1);
		rr = axi_rsp.bresp;
		@(posedge aclk);
	endtask : wr
	task rd(input logic [4:0] a);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		do @(negedge aclk); while (axi_rsp.arready !== 1'b1);
		@(posedge aclk);
		axi_req.arvalid <= 1'b0;
		do @(negedge aclk); while (axi_rsp.rvalid !== 1'b1);
		rv = axi_rsp.rdata;
		rr = axi_rsp.rresp;
		@(posedge aclk);
	endtask : rd
	task xck_period(output int n);
		while (pin_out.xck_out !== 1'b1) @(negedge aclk);
		while (pin_out.xck_out !== 1'b0) @(negedge aclk);
		n = 0;
		while (pin_out.xck_out !== 1'b1)
		begin
			@(negedge aclk);
			n++;
		end
		while (pin_out.xck_out !== 1'b0)
		begin
			@(negedge aclk);
			n++;
		end
		@(posedge aclk);
	endtask : xck_period
	////////////////////////////////////////////////////////////////
	task t_reset;
		rd(`SPBCG_OFF_STAT);
		chk(rv, 32'h0000_0004);
		rd(`SPBCG_OFF_CTRL);
		chk(rv, 32'h0000_0000);
		rd(`SPBCG_OFF_DIV);
		chk(rv, 32'h0000_0000);
		rd(5'h10);
		chk(rr, `SPBCG_RESP_ERR);
		wr(`SPBCG_OFF_DIV, 32'h0000_FFFF, 4'h3);
		rd(`SPBCG_OFF_DIV);
		chk(rv, 32'h0000_0FFF);
		wr(`SPBCG_OFF_DIV, 32'h0000_0001, 4'h3);
	endtask : t_reset
	task automatic t_tx;
		int dbl_t[4] = '{0, 1, 0, 0};
		int sz_t[4] = '{3, 3, 0, 4};
		int per;
		int nb;
		logic [8:0] d;
		logic s;
		time t0;
		for (int k = 0; k < 4; k++)
		begin
			per = dbl_t[k] ? 16 : 32;
			nb = 5 + sz_t[k];
			wr(`SPBCG_OFF_STAT, 32'(dbl_t[k]) << 6, 4'h1);
			wr(`SPBCG_OFF_CTRL, (32'(sz_t[k]) << 8) | 32'h2, 4'h3);
			fork
				u_spbcg_peer.rcv(per, nb, d, s, t0);
				wr(`SPBCG_OFF_DATA, 32'h0000_01A5, 4'h1);
			join
			@(posedge aclk);
			chk(d, 9'h1A5 & (9'h1FF >> (9 - nb)));
			chk(s, 1'b1);
		end
	endtask : t_tx
	task automatic t_b2b;
		logic [8:0] d1;
		logic [8:0] d2;
		logic s;
		time t0;
		time t1;
		wr(`SPBCG_OFF_STAT, 32'h0, 4'h1);
		wr(`SPBCG_OFF_CTRL, 32'h0302, 4'h3);
		fork
			begin
				u_spbcg_peer.rcv(32, 8, d1, s, t0);
				u_spbcg_peer.rcv(32, 8, d2, s, t1);
			end
			begin
				wr(`SPBCG_OFF_DATA, 32'h3C, 4'h1);
				rv = '0;
				for (int i = 0; i < 100 && rv[2] !== 1'b1; i++)
					rd(`SPBCG_OFF_STAT);
				wr(`SPBCG_OFF_DATA, 32'hC3, 4'h1);
			end
		join
		@(posedge aclk);
		chk(d1, 9'h03C);
		chk(d2, 9'h0C3);
		chk(32'(t1 - t0), 32'd3200);
	endtask : t_b2b
	task automatic t_rx;
		logic [2:0] par_t[3] = '{3'b011, 3'b110, 3'b000};
		wr(`SPBCG_OFF_CTRL, 32'h1301, 4'h3);
		u_spbcg_peer.send(32, 8, 9'h05A, 1'b0, 1'b0, 1'b1);
		rd(`SPBCG_OFF_STAT);
		chk(rv[0], 1'b1);
		chk(irq.rx_done, 1'b1);
		rd(`SPBCG_OFF_DATA);
		chk(rv[8:0], 9'h05A);
		chk(irq.rx_done, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			wr(`SPBCG_OFF_CTRL, 32'h0341 | (32'(par_t[k][2]) << 7), 4'h3);
			u_spbcg_peer.send(32, 8, 9'h05A, 1'b1, par_t[k][1], 1'b1);
			rd(`SPBCG_OFF_STAT);
			chk(rv[5], par_t[k][0]);
			rd(`SPBCG_OFF_DATA);
		end
		wr(`SPBCG_OFF_CTRL, 32'h0301, 4'h3);
		u_spbcg_peer.send(32, 8, 9'h0F0, 1'b0, 1'b0, 1'b0);
		rd(`SPBCG_OFF_STAT);
		chk(rv[3], 1'b1);
		rd(`SPBCG_OFF_DATA);
		u_spbcg_peer.send(32, 8, 9'h011, 1'b0, 1'b0, 1'b1);
		u_spbcg_peer.send(32, 8, 9'h022, 1'b0, 1'b0, 1'b1);
		u_spbcg_peer.send(32, 8, 9'h033, 1'b0, 1'b0, 1'b1);
		rd(`SPBCG_OFF_STAT);
		chk(rv[4], 1'b1);
		rd(`SPBCG_OFF_DATA);
		chk(rv[8:0], 9'h011);
		rd(`SPBCG_OFF_DATA);
		chk(rv[8:0], 9'h022);
	endtask : t_rx
	task automatic t_sync;
		int n;
		chk(pin_out.xck_oe, 1'b0);
		wr(`SPBCG_OFF_CTRL, 32'h0014, 4'h3);
		chk(pin_out.xck_oe, 1'b1);
		xck_period(n);
		chk(n, 4);
		wr(`SPBCG_OFF_STAT, 32'h40, 4'h1);
		xck_period(n);
		chk(n, 4);
		wr(`SPBCG_OFF_CTRL, 32'h0004, 4'h3);
		chk(pin_out.xck_oe, 1'b0);
		wr(`SPBCG_OFF_CTRL, 32'h0010, 4'h3);
		chk(pin_out.xck_oe, 1'b0);
	endtask : t_sync
	// Slave runs in both polarities; double speed is left set to show it has no effect here.
	task automatic t_slave;
		logic [15:0] got;
		for (int p = 0; p < 2; p++)
		begin
			wr(`SPBCG_OFF_CTRL, 32'h6307 | (32'(p) << 3), 4'h3);
			wr(`SPBCG_OFF_STAT, 32'h42, 4'h1);
			chk(irq.tx_done, 1'b0);
			wr(`SPBCG_OFF_DATA, 32'hA5, 4'h1);
			chk(rr, `SPBCG_RESP_OK);
			chk(irq.tx_empty, 1'b0);
			u_spbcg_peer.slave_run(8, 1'(p), 16'hFE78, got);
			chk(got, 16'hFF4A);
			chk(irq.tx_done, 1'b1);
			chk(irq.tx_empty, 1'b1);
			rd(`SPBCG_OFF_DATA);
			chk(rv[8:0], 9'h03C);
		end
	endtask : t_slave
	////////////////////////////////////////////////////////////////
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_tx;
		t_b2b;
		t_rx;
		t_sync;
		t_slave;
		tally_and_finish;
	end
endmodule : spbcg_core_tb

/* File: spbcg_peer.sv */
`timescale 1ns/1ns
module spbcg_peer
(
	input wire logic aclk,
	input wire logic txd,
	output logic rxd,
	output logic xck
);
	// The line idles high; the transfer clock stands still at its idle level outside slave runs.
	initial rxd = 1'b1;
	initial xck = 1'b0;
	////////////////////////////////////////////////////////////////
	task automatic send(input int per, input int nb, input logic [8:0] d, input logic pe, input logic pb,
		input logic stp);
		rxd <= 1'b0;
		repeat (per) @(posedge aclk);
		for (int i = 0; i < nb; i++)
		begin
			rxd <= d[i];
			repeat (per) @(posedge aclk);
		end
		if (pe)
		begin
			rxd <= pb;
			repeat (per) @(posedge aclk);
		end
		rxd <= stp;
		repeat (per) @(posedge aclk);
		rxd <= 1'b1;
		repeat (per) @(posedge aclk);
	endtask : send
	////////////////////////////////////////////////////////////////
	// Samples at falling clock edges so that the design's own edge never races the look.
	task automatic rcv(input int per, input int nb, output logic [8:0] d, output logic stp, output time t0);
		d = '0;
		while (txd !== 1'b0) @(negedge aclk);
		t0 = $time;
		repeat (per / 2) @(negedge aclk);
		for (int i = 0; i < nb; i++)
		begin
			repeat (per) @(negedge aclk);
			d[i] = txd;
		end
		repeat (per) @(negedge aclk);
		stp = txd;
	endtask : rcv
	////////////////////////////////////////////////////////////////
	// Clocks the port as its slave. Half must exceed two cycles to keep the clock below a quarter
	// of the system rate. The line moves on the change edge and txd is read just before the sample edge.
	task automatic slave_run(input int half, input logic pol, input logic [15:0] out, output logic [15:0] got);
		got = '0;
		xck <= pol;
		repeat (half) @(posedge aclk);
		for (int i = 0; i < 16; i++)
		begin
			xck <= ~pol;
			rxd <= out[i];
			repeat (half - 1) @(posedge aclk);
			@(negedge aclk);
			got[i] = txd;
			@(posedge aclk);
			xck <= pol;
			repeat (half) @(posedge aclk);
		end
	endtask : slave_run
endmodule : spbcg_peer

/* File: spbcg_pkg.sv */
`include "spbcg_consts.svh"
package spbcg_pkg;

	typedef enum logic [3:0] {
		MD_NORMAL = 4'h1,
		MD_DOUBLE = 4'h2,
		MD_MASTER = 4'h4,
		MD_SLAVE = 4'h8
	} spbcg_mode_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h1,
		RX_BUSY = 2'h2
	} spbcg_rx_e;

	typedef struct packed {
		logic [`SPBCG_AW-1:0] awaddr;
		logic awvalid, wvalid, bready, arvalid, rready;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [`SPBCG_AW-1:0] araddr;
	} spbcg_axi_req_s;

	typedef struct packed {
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} spbcg_axi_rsp_s;

	typedef struct packed {
		logic rxd, xck;
	} spbcg_pin_in_s;

	typedef struct packed {
		logic txd, xck_out, xck_oe;
	} spbcg_pin_out_s;

	typedef struct packed {
		logic rx_done, tx_done, tx_empty;
	} spbcg_irq_s;

	typedef struct packed {
		logic rx_en, tx_en, sync, pol, dir, stop2, par_en, par_odd, pwr_off, dbl;
		logic [2:0] size, ie;
		logic [11:0] div, bcnt;
		logic [3:0] txdiv, txcnt;
		logic [8:0] txbuf;
		logic [`SPBCG_FRAME_W-1:0] txsh;
		logic txfull, txd, txact, txc;
		logic ck, ck_prev, xk_m1, xk_m2, xk_m3, rx_m1, rx_m2;
		spbcg_rx_e rst;
		logic [3:0] rcnt, ridx;
		logic [2:0] rsmp;
		logic [8:0] rdat;
		logic rpar, rpe, dor, bvalid, rvalid;
		logic [1:0][10:0] fq;
		logic [1:0] fcnt, bresp, rresp;
		logic [31:0] rdata;
	} spbcg_state_s;

endpackage : spbcg_pkg
